// ===== hw/ctsel_pkg.sv
`default_nettype none

package ctsel_pkg;

  // number of continuous-time blocks in the analog column
  localparam int unsigned CTSEL_BLOCKS = 4;

  // register indices; byte address on the bus is four times the index
  localparam logic [7:0] CTSEL_IDX_CTRL_ZERO [CTSEL_BLOCKS] =
    '{8'h71, 8'h75, 8'h79, 8'h7D};
  localparam logic [7:0] CTSEL_IDX_INPUT_SEL [CTSEL_BLOCKS] =
    '{8'h72, 8'h76, 8'h7A, 8'h7E};
  localparam logic [7:0] CTSEL_IDX_STATUS = 8'h60;

  // bank select bit and index field of the byte address
  localparam int unsigned CTSEL_ADR_W    = 11;
  localparam int unsigned CTSEL_BANK_BIT = 10;
  localparam int unsigned CTSEL_IDX_LSB  = 2;
  localparam int unsigned CTSEL_IDX_MSB  = 9;

  // reset values
  localparam logic [7:0] CTSEL_CTRL_ZERO_RST = 8'h00;
  localparam logic [7:0] CTSEL_INPUT_SEL_RST = 8'h00;

  // field layout of the input-select register
  localparam int unsigned CTSEL_BUS_EN_BIT = 7;
  localparam int unsigned CTSEL_CMP_EN_BIT = 6;
  localparam int unsigned CTSEL_INV_LSB    = 3;
  localparam int unsigned CTSEL_NONINV_LSB = 0;
  localparam int unsigned CTSEL_SEL_W      = 3;

  // mux codes with no physical source behind them
  localparam logic [2:0] CTSEL_NONINV_FLOAT = 3'h7;
  localparam logic [2:0] CTSEL_INV_RESERVED = 3'h7;

  // status register layout
  localparam int unsigned CTSEL_ST_CMP_LSB   = 0;
  localparam int unsigned CTSEL_ST_BUS_BIT   = 4;
  localparam int unsigned CTSEL_ST_FLOAT_LSB = 8;
  localparam int unsigned CTSEL_ST_RSVD_LSB  = 12;

  // comparator synchroniser depth
  localparam int unsigned CTSEL_SYNC_STAGES = 3;

  // bus slave phase
  typedef enum logic {
    CTSEL_BUS_IDLE = 1'b0,
    CTSEL_BUS_ACK  = 1'b1
  } ctsel_bus_t;

endpackage : ctsel_pkg

`default_nettype wire

// ===== hw/ctsel_blk.sv
`timescale 1ns/1ps
`default_nettype none

// one continuous-time block: field split and comparator capture
module ctsel_blk (
  input  wire logic       clk_in,          // system clock
  input  wire logic       rst_in,          // async reset, high
  input  wire logic [7:0] input_sel_in,    // stored input-select byte
  input  wire logic       cmp_raw_in,      // comparator, async
  output logic      [2:0] noninv_sel_out,  // non-inverting mux code
  output logic      [2:0] inv_sel_out,     // inverting mux code
  output logic            bus_en_out,      // op-amp to column bus
  output logic            drive_en_out,    // comparator driver enable
  output logic            cmp_out,         // filtered comparator
  output logic            float_out,       // non-inv input floating
  output logic            rsvd_out         // inverting code reserved
);

  logic [ctsel_pkg::CTSEL_SYNC_STAGES-1:0] sync_q;
  logic [ctsel_pkg::CTSEL_SYNC_STAGES-1:0] sync_d;
  logic                                    cmp_q;
  logic                                    cmp_d;

  // fields straight from the stored bits, no extra stage
  assign bus_en_out   = input_sel_in[ctsel_pkg::CTSEL_BUS_EN_BIT];
  assign drive_en_out = input_sel_in[ctsel_pkg::CTSEL_CMP_EN_BIT];
  assign inv_sel_out  = input_sel_in[ctsel_pkg::CTSEL_INV_LSB +:
                                     ctsel_pkg::CTSEL_SEL_W];
  assign noninv_sel_out = input_sel_in[ctsel_pkg::CTSEL_NONINV_LSB +:
                                       ctsel_pkg::CTSEL_SEL_W];
  // flag codes that leave an input open so software can spot them
  assign float_out = (noninv_sel_out == ctsel_pkg::CTSEL_NONINV_FLOAT);
  assign rsvd_out  = (inv_sel_out == ctsel_pkg::CTSEL_INV_RESERVED);
  assign cmp_out   = cmp_q;

  // shift in; accept a level only once the last two stages agree,
  // which rejects a single-cycle glitch from the analog side
  always_comb begin
    sync_d = {sync_q[ctsel_pkg::CTSEL_SYNC_STAGES-2:0], cmp_raw_in};
    cmp_d  = cmp_q;
    if (sync_q[1] == sync_q[2]) begin
      cmp_d = sync_q[2];
    end
  end

  // registers only
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      sync_q <= '0;
      cmp_q  <= 1'b0;
    end else begin
      sync_q <= sync_d;
      cmp_q  <= cmp_d;
    end
  end

endmodule : ctsel_blk

`default_nettype wire

// ===== hw/ctsel_regs.sv
// How it works
// - input-select registers at 72h,76h,7Ah,7Eh, both banks
// - control-0 registers at 71h,75h,79h,7Dh, both banks
// - bit 7 connects op-amp to column bus
// - bit 6 enables comparator column driver
// - column comparator bus low when nobody drives
// - bits 5:3 pick inverting input, 111 reserved
// - bits 2:0 pick non-inverting input source
//
// The Wishbone interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module ctsel_regs #(
  parameter int unsigned BLOCKS = ctsel_pkg::CTSEL_BLOCKS, // blocks
  parameter int unsigned ADR_W  = ctsel_pkg::CTSEL_ADR_W   // byte addr
) (
  input  wire logic                clk_in,                // 100 MHz
  input  wire logic                rst_in,                // async, high
  // classic wishbone slave
  input  wire logic                wb_cyc_in,             // cycle
  input  wire logic                wb_stb_in,             // strobe
  input  wire logic                wb_we_in,              // write
  input  wire logic [ADR_W-1:0]    wb_adr_in,             // byte address
  input  wire logic [3:0]          wb_sel_in,             // byte enables
  input  wire logic [31:0]         wb_dat_in,             // write data
  output logic      [31:0]         wb_dat_out,            // read data
  output logic                     wb_ack_out,            // acknowledge
  // analog column
  input  wire logic [BLOCKS-1:0]   cmp_result_in,         // comparators
  output logic      [3*BLOCKS-1:0] noninv_input_sel_out,  // 3 bits each
  output logic      [3*BLOCKS-1:0] inv_input_sel_out,     // 3 bits each
  output logic      [BLOCKS-1:0]   opamp_column_bus_en_out, // bus switch
  output logic      [BLOCKS-1:0]   cmp_column_drive_en_out, // driver en
  output logic                     cmp_column_bus_out,    // column bus
  output logic      [8*BLOCKS-1:0] ctrl_zero_out          // control-0
);

  // -------- storage --------
  logic [7:0]             ctrl_zero_q [BLOCKS];
  logic [7:0]             ctrl_zero_d [BLOCKS];
  logic [7:0]             input_sel_q [BLOCKS];
  logic [7:0]             input_sel_d [BLOCKS];

  // -------- bus slave state --------
  ctsel_pkg::ctsel_bus_t  bus_q;
  ctsel_pkg::ctsel_bus_t  bus_d;
  logic [31:0]            rdata_q;
  logic [31:0]            rdata_d;

  // -------- column state --------
  logic                   cmp_bus_q;
  logic                   cmp_bus_d;

  // -------- per-block decode results --------
  logic [BLOCKS-1:0]      cmp_filt;
  logic [BLOCKS-1:0]      float_flag;
  logic [BLOCKS-1:0]      rsvd_flag;
  logic [BLOCKS-1:0]      drive_en;

  // -------- address decode helpers --------
  logic [7:0]             req_idx;
  logic                   req_valid;
  logic                   wr_fire;
  logic [31:0]            status_word;

  // index of the request; the bank bit is dropped on purpose so both
  // banks see the same registers
  assign req_idx = wb_adr_in[ctsel_pkg::CTSEL_IDX_MSB:
                             ctsel_pkg::CTSEL_IDX_LSB];

  // request present on the bus
  assign req_valid = wb_cyc_in & wb_stb_in;

  // writes land on the edge where the master sees ack high
  assign wr_fire = req_valid & wb_we_in & (bus_q == ctsel_pkg::CTSEL_BUS_ACK);

  // returns the block whose control-0 register sits at idx, or BLOCKS
  function automatic int unsigned ctrl_zero_hit(input logic [7:0] idx);
    int unsigned hit;
    hit = BLOCKS;
    for (int unsigned b = 0; b < BLOCKS; b++) begin
      if (idx == ctsel_pkg::CTSEL_IDX_CTRL_ZERO[b]) begin
        hit = b;
      end
    end
    return hit;
  endfunction : ctrl_zero_hit

  // returns the block whose input-select register sits at idx, or BLOCKS
  function automatic int unsigned input_sel_hit(input logic [7:0] idx);
    int unsigned hit;
    hit = BLOCKS;
    for (int unsigned b = 0; b < BLOCKS; b++) begin
      if (idx == ctsel_pkg::CTSEL_IDX_INPUT_SEL[b]) begin
        hit = b;
      end
    end
    return hit;
  endfunction : input_sel_hit

  // only the low byte lane carries data; other lanes are ignored
  function automatic logic [7:0] merge_low(input logic [7:0]  old_val,
                                           input logic [31:0] wdat,
                                           input logic [3:0]  sel);
    logic [7:0] res;
    res = old_val;
    if (sel[0]) begin
      res = wdat[7:0];
    end
    return res;
  endfunction : merge_low

  // one instance per block splits fields and captures its comparator
  for (genvar g = 0; g < BLOCKS; g++) begin : g_blk
    ctsel_blk u_blk (
      .clk_in         (clk_in),
      .rst_in         (rst_in),
      .input_sel_in   (input_sel_q[g]),
      .cmp_raw_in     (cmp_result_in[g]),
      .noninv_sel_out (noninv_input_sel_out[3*g +: 3]),
      .inv_sel_out    (inv_input_sel_out[3*g +: 3]),
      .bus_en_out     (opamp_column_bus_en_out[g]),
      .drive_en_out   (drive_en[g]),
      .cmp_out        (cmp_filt[g]),
      .float_out      (float_flag[g]),
      .rsvd_out       (rsvd_flag[g])
    );
    assign ctrl_zero_out[8*g +: 8] = ctrl_zero_q[g];
  end

  assign cmp_column_drive_en_out = drive_en;

  // read-only status; lets software see the column as the logic sees it
  always_comb begin
    status_word = 32'h0000_0000;
    status_word[ctsel_pkg::CTSEL_ST_CMP_LSB +: BLOCKS]   = cmp_filt;
    status_word[ctsel_pkg::CTSEL_ST_BUS_BIT]             = cmp_bus_q;
    status_word[ctsel_pkg::CTSEL_ST_FLOAT_LSB +: BLOCKS] = float_flag;
    status_word[ctsel_pkg::CTSEL_ST_RSVD_LSB +: BLOCKS]  = rsvd_flag;
  end

  // wired-or of enabled drivers; an idle bus settles low, as the
  // pull-down outside the blocks would make it
  always_comb begin
    cmp_bus_d = 1'b0;
    for (int unsigned b = 0; b < BLOCKS; b++) begin
      if (drive_en[b] && cmp_filt[b]) begin
        cmp_bus_d = 1'b1;
      end
    end
  end

  // column bus register; keeps the output glitch free
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cmp_bus_q <= 1'b0;
    end else begin
      cmp_bus_q <= cmp_bus_d;
    end
  end

  // next register contents; a write to an unmapped index is dropped
  always_comb begin
    int unsigned cz;
    int unsigned is;
    cz = ctrl_zero_hit(req_idx);
    is = input_sel_hit(req_idx);
    for (int unsigned b = 0; b < BLOCKS; b++) begin
      ctrl_zero_d[b] = ctrl_zero_q[b];
      input_sel_d[b] = input_sel_q[b];
    end
    if (wr_fire) begin
      for (int unsigned b = 0; b < BLOCKS; b++) begin
        if (cz == b) begin
          ctrl_zero_d[b] = merge_low(ctrl_zero_q[b], wb_dat_in, wb_sel_in);
        end
        // code 111 is stored as written; the status flag reports it
        if (is == b) begin
          input_sel_d[b] = merge_low(input_sel_q[b], wb_dat_in, wb_sel_in);
        end
      end
    end
  end

  // configuration storage, zero after reset
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      for (int unsigned b = 0; b < BLOCKS; b++) begin
        ctrl_zero_q[b] <= ctsel_pkg::CTSEL_CTRL_ZERO_RST;
        input_sel_q[b] <= ctsel_pkg::CTSEL_INPUT_SEL_RST;
      end
    end else begin
      for (int unsigned b = 0; b < BLOCKS; b++) begin
        ctrl_zero_q[b] <= ctrl_zero_d[b];
        input_sel_q[b] <= input_sel_d[b];
      end
    end
  end

  // bus phase and read data; one wait state, ack dropped right after
  // so a held strobe never double-acks the same request
  always_comb begin
    int unsigned cz;
    int unsigned is;
    cz      = ctrl_zero_hit(req_idx);
    is      = input_sel_hit(req_idx);
    bus_d   = ctsel_pkg::CTSEL_BUS_IDLE;
    rdata_d = rdata_q;
    case (bus_q)
      ctsel_pkg::CTSEL_BUS_IDLE: begin
        if (req_valid) begin
          bus_d   = ctsel_pkg::CTSEL_BUS_ACK;
          rdata_d = 32'h0000_0000;              // unmapped reads as zero
          if (cz < BLOCKS) begin
            rdata_d[7:0] = ctrl_zero_q[cz];
          end else if (is < BLOCKS) begin
            rdata_d[7:0] = input_sel_q[is];
          end else if (req_idx == ctsel_pkg::CTSEL_IDX_STATUS) begin
            rdata_d = status_word;
          end
        end
      end
      ctsel_pkg::CTSEL_BUS_ACK: begin
        bus_d = ctsel_pkg::CTSEL_BUS_IDLE;
      end
      default: begin
        bus_d = ctsel_pkg::CTSEL_BUS_IDLE;
      end
    endcase
  end

  // bus slave registers
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      bus_q   <= ctsel_pkg::CTSEL_BUS_IDLE;
      rdata_q <= 32'h0000_0000;
    end else begin
      bus_q   <= bus_d;
      rdata_q <= rdata_d;
    end
  end

  // ack only while the request is still up, so an aborted cycle
  // cannot leave a stray acknowledge behind
  assign wb_ack_out = req_valid & (bus_q == ctsel_pkg::CTSEL_BUS_ACK);
  assign wb_dat_out = rdata_q;
  assign cmp_column_bus_out = cmp_bus_q;

endmodule : ctsel_regs

`default_nettype wire

// ===== testbench/ctsel_regs_properties.sv
`timescale 1ns/1ps
`default_nettype none

// protocol and field checks on the select bank ports
module ctsel_regs_props #(
  parameter int unsigned BLOCKS = 4,
  parameter int unsigned ADR_W  = 11
) (
  input wire logic                clk_in,                  // clock
  input wire logic                rst_in,                  // reset
  input wire logic                wb_cyc_in,               // cycle
  input wire logic                wb_stb_in,               // strobe
  input wire logic                wb_we_in,                // write
  input wire logic [ADR_W-1:0]    wb_adr_in,               // address
  input wire logic [3:0]          wb_sel_in,               // lanes
  input wire logic [31:0]         wb_dat_in,               // wdata
  input wire logic [31:0]         wb_dat_out,              // rdata
  input wire logic                wb_ack_out,              // ack
  input wire logic [BLOCKS-1:0]   cmp_result_in,           // cmp
  input wire logic [3*BLOCKS-1:0] noninv_input_sel_out,    // codes
  input wire logic [3*BLOCKS-1:0] inv_input_sel_out,       // codes
  input wire logic [BLOCKS-1:0]   opamp_column_bus_en_out, // switch
  input wire logic [BLOCKS-1:0]   cmp_column_drive_en_out, // driver
  input wire logic                cmp_column_bus_out,      // bus
  input wire logic [8*BLOCKS-1:0] ctrl_zero_out            // ctrl-0
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  // bank bit is masked so both banks count as the same place
  sequence s_wr(a);
    wb_ack_out && wb_we_in && wb_sel_in[0] && wb_adr_in[9:0] == a;
  endsequence
  sequence s_req;
    wb_cyc_in && wb_stb_in && !wb_ack_out;
  endsequence

  a_ack_follows: assert property (s_req |=> wb_ack_out)
    else $error("request not acked next cycle");
  a_ack_pulse: assert property (wb_ack_out |=> !wb_ack_out)
    else $error("ack longer than one cycle");
  a_bus_en_bit: assert property (s_wr(10'h1C8) |=>
    opamp_column_bus_en_out[0] == $past(wb_dat_in[7]))
    else $error("bus switch not from bit 7");
  a_drive_en_bit: assert property (s_wr(10'h1E8) |=>
    cmp_column_drive_en_out[2] == $past(wb_dat_in[6]))
    else $error("driver enable not from bit 6");
  a_inv_field: assert property (s_wr(10'h1D8) |=>
    inv_input_sel_out[5:3] == $past(wb_dat_in[5:3]))
    else $error("inverting code wrong");
  a_noninv_field: assert property (s_wr(10'h1F8) |=>
    noninv_input_sel_out[11:9] == $past(wb_dat_in[2:0]))
    else $error("non-inverting code wrong");
  a_ctrl_zero_wr: assert property (s_wr(10'h1E4) |=>
    ctrl_zero_out[23:16] == $past(wb_dat_in[7:0]))
    else $error("control-0 byte wrong");
  a_bus_idle_low: assert property (cmp_column_drive_en_out == '0 |=>
    !cmp_column_bus_out)
    else $error("column bus high with no driver");
  a_hold_no_write: assert property (!(wb_ack_out && wb_we_in) |=>
    $stable({noninv_input_sel_out, inv_input_sel_out, ctrl_zero_out}))
    else $error("outputs moved without a write");
  a_read_back: assert property (wb_ack_out && !wb_we_in &&
    wb_adr_in[9:0] == 10'h1C8 |-> wb_dat_out == {24'h000000,
    opamp_column_bus_en_out[0], cmp_column_drive_en_out[0],
    inv_input_sel_out[2:0], noninv_input_sel_out[2:0]})
    else $error("read data differs from stored byte");
endmodule : ctsel_regs_props

bind ctsel_regs ctsel_regs_props #(.BLOCKS(BLOCKS), .ADR_W(ADR_W)) u_props (
  .clk_in(clk_in), .rst_in(rst_in), .wb_cyc_in(wb_cyc_in),
  .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in),
  .wb_sel_in(wb_sel_in), .wb_dat_in(wb_dat_in), .wb_dat_out(wb_dat_out),
  .wb_ack_out(wb_ack_out), .cmp_result_in(cmp_result_in),
  .noninv_input_sel_out(noninv_input_sel_out),
  .inv_input_sel_out(inv_input_sel_out),
  .opamp_column_bus_en_out(opamp_column_bus_en_out),
  .cmp_column_drive_en_out(cmp_column_drive_en_out),
  .cmp_column_bus_out(cmp_column_bus_out), .ctrl_zero_out(ctrl_zero_out));

`default_nettype wire

// ===== testbench/ctsel_regs_bench.sv
`timescale 1ns/1ps
`default_nettype none

module ctsel_regs_bench;
  typedef struct {logic [10:0] a; logic [7:0] d;} ctsel_row_t;
  logic        clk_in = 1'b0;
  logic        rst_in = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [10:0] adr = 11'h000;
  logic [3:0]  sel = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [3:0]  cmp = 4'h0;
  logic [31:0] rdat, dout, cz_o;
  logic [11:0] non_o, inv_o;
  logic [3:0]  bus_o, drv_o;
  logic        cbus, ack;
  logic [7:0]  isel [4] = '{default: 8'h00};
  logic [7:0]  cz [4] = '{default: 8'h00};
  int          err_count = 0;
  int          checks_done = 0;
  // mixed banks; non-inverting code 111 never written
  ctsel_row_t  rows [11] = '{'{11'h1C8, 8'h80}, '{11'h5D8, 8'h49},
    '{11'h1E8, 8'hD2}, '{11'h5F8, 8'h1B}, '{11'h1C8, 8'h64},
    '{11'h1D4, 8'hA5}, '{11'h5E8, 8'h2D}, '{11'h1F8, 8'hB6},
    '{11'h5F4, 8'h3C}, '{11'h1C4, 8'hFF}, '{11'h1E4, 8'h5A}};

  ctsel_regs dut (
    .clk_in(clk_in), .rst_in(rst_in), .wb_cyc_in(cyc), .wb_stb_in(stb),
    .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat),
    .wb_dat_out(dout), .wb_ack_out(ack), .cmp_result_in(cmp),
    .noninv_input_sel_out(non_o), .inv_input_sel_out(inv_o),
    .opamp_column_bus_en_out(bus_o), .cmp_column_drive_en_out(drv_o),
    .cmp_column_bus_out(cbus), .ctrl_zero_out(cz_o));

  // 100 MHz clock
  always #5 clk_in = ~clk_in;

  task automatic check(input string n, input logic [31:0] s, e);
    checks_done++;
    if (s !== e) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask : check

  // single classic cycle; no latency assumed, watchdog ends a hang
  task automatic xfer(input logic w, input logic [10:0] a,
                      input logic [3:0] s, input logic [31:0] d,
                      output logic [31:0] r);
    @(posedge clk_in);
    {cyc, stb, we} <= {2'b11, w};
    adr <= a;
    sel <= s;
    wdat <= d;
    do @(posedge clk_in); while (ack !== 1'b1);
    r = dout;
    {cyc, stb} <= 2'b00;
  endtask : xfer

  // compares every column output but the comparator bus with the bench's copy of the bank
  task automatic outs;
    logic [11:0] en, ei;
    logic [3:0]  eb, ed;
    logic [31:0] ec;
    @(negedge clk_in);
    for (int k = 0; k < 4; k++) begin
      en[3*k+:3] = isel[k][2:0];
      ei[3*k+:3] = isel[k][5:3];
      eb[k] = isel[k][7];
      ed[k] = isel[k][6];
      ec[8*k+:8] = cz[k];
    end
    check("noninv", 32'(non_o), 32'(en));
    check("inv", 32'(inv_o), 32'(ei));
    check("bus_en", 32'(bus_o), 32'(eb));
    check("drive_en", 32'(drv_o), 32'(ed));
    check("ctrl_zero", cz_o, ec);
  endtask : outs

  task automatic summarize;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : summarize

  // watchdog sized well beyond the roughly 125 cycles of the run
  initial begin
    repeat (3000) @(posedge clk_in);
    err_count++;
    summarize();
  end

  initial begin
    repeat (3) @(posedge clk_in);
    rst_in <= 1'b0;
    outs();
    foreach (rows[r]) begin
      xfer(1'b1, rows[r].a, 4'h1, {24'h0, rows[r].d}, rdat);
      if (rows[r].a[3:2] == 2'b10) isel[rows[r].a[5:4]] = rows[r].d;
      else cz[rows[r].a[5:4]] = rows[r].d;
      xfer(1'b0, rows[r].a ^ 11'h400, 4'h1, 32'h0, rdat);
      check("readback", rdat, {24'h0, rows[r].d});
      outs();
    end
    // unmapped index reads zero; a write with lane 0 off is dropped
    xfer(1'b1, 11'h1CC, 4'hF, 32'hFF, rdat);
    xfer(1'b0, 11'h1CC, 4'hF, 32'h0, rdat);
    check("unmapped", rdat, 32'h0);
    xfer(1'b1, 11'h1C8, 4'hE, 32'hFF, rdat);
    outs();
    // comparator of a disabled block must not reach the column bus;
    // inputs move on the rising edge, so wait for one first
    @(posedge clk_in);
    cmp <= 4'h4;
    repeat (8) @(posedge clk_in);
    check("cbus_off", 32'(cbus), 32'h0);
    cmp <= 4'h2;
    repeat (8) @(posedge clk_in);
    check("cbus_on", 32'(cbus), 32'h1);
    // status: filtered comparators in 3:0, column bus in bit 4
    xfer(1'b0, 11'h180, 4'h1, 32'h0, rdat);
    check("status", rdat, 32'h0000_0012);
    xfer(1'b1, 11'h1D8, 4'h1, 32'h09, rdat);
    isel[1] = 8'h09;
    repeat (8) @(posedge clk_in);
    check("cbus_idle", 32'(cbus), 32'h0);
    // no driver enabled anywhere while every comparator is high
    xfer(1'b1, 11'h5C8, 4'h1, 32'h24, rdat);
    isel[0] = 8'h24;
    cmp <= 4'hF;
    repeat (8) @(posedge clk_in);
    check("cbus_none", 32'(cbus), 32'h0);
    outs();
    // second reset mid-run clears the whole bank
    @(posedge clk_in);
    rst_in <= 1'b1;
    isel = '{default: 8'h00};
    cz = '{default: 8'h00};
    outs();
    check("cbus_rst", 32'(cbus), 32'h0);
    check("dout_rst", dout, 32'h0);
    @(posedge clk_in);
    rst_in <= 1'b0;
    // first request right after release must work and read zero
    xfer(1'b0, 11'h5C8, 4'h1, 32'h0, rdat);
    check("rst_read", rdat, 32'h0);
    outs();
    summarize();
  end
endmodule : ctsel_regs_bench

`default_nettype wire
